// ### design/pfl_pkg.sv
`default_nettype none
package pfl_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 6;
    localparam logic [5:0]  OFF_DIR    = 6'h00;
    localparam logic [5:0]  OFF_DATA   = 6'h04;
    localparam logic [5:0]  OFF_PULLUP = 6'h08;
    localparam logic [5:0]  OFF_PULLDN = 6'h0c;
    localparam logic [5:0]  OFF_DIE    = 6'h10;
    localparam logic [5:0]  OFF_PIN    = 6'h14;
    localparam logic [5:0]  OFF_ALT    = 6'h18;
    localparam logic [5:0]  OFF_ISTAT  = 6'h1c;
    localparam logic [5:0]  OFF_ICLR   = 6'h20;
    localparam logic [5:0]  OFF_IEN    = 6'h24;
    // ------------------------------------------------------------
    // reset values and pin set
    // ------------------------------------------------------------
    localparam logic [7:0]  PIN_MASK   = 8'hf9;
    localparam logic [7:0]  DIE_RST    = 8'hf9;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [7:0]  P7_BIT     = 8'h80;
    localparam logic [11:0] ALT_RST    = 12'h000;
    // ------------------------------------------------------------
    // alternate function control fields
    // ------------------------------------------------------------
    localparam int ALT_W      = 12;
    localparam int ALT_T2EN   = 0;
    localparam int ALT_T2SEL  = 1;
    localparam int ALT_LP0EN  = 2;
    localparam int ALT_LP1EN  = 3;
    localparam int ALT_LP2EN  = 4;
    localparam int ALT_LP2SEL = 5;
    localparam int ALT_CMPOEN = 6;
    localparam int ALT_NEGLO  = 7;
    localparam int ALT_NEGHI  = 8;
    localparam int ALT_ISEL   = 9;
    localparam int ALT_XRST   = 10;
    localparam int ALT_P7ANA  = 11;
    localparam logic [1:0] NEG_P6 = 2'h0;
    localparam logic [1:0] NEG_P4 = 2'h1;
    localparam logic [1:0] NEG_P3 = 2'h2;
    // ------------------------------------------------------------
    // interrupt status bits and bus answers
    // ------------------------------------------------------------
    localparam int         IRQ_W      = 2;
    localparam int         ST_EXTIRQ  = 0;
    localparam int         ST_WAKE    = 1;
    localparam logic [1:0] IRQ_RST    = 2'h0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### design/pfl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // pfl_sync
`default_nettype wire

// ### design/pfl_port_a.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_port_a #(
    parameter int ADDR_W = pfl_pkg::ADDR_W
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    input  wire logic [7:0]        pinIn,
    output var  logic [7:0]        pinOut,
    output var  logic [7:0]        pinOeN,
    output var  logic [7:0]        pullUpEn,
    output var  logic [7:0]        pullDownEn,
    output var  logic [7:0]        digInEn,
    output var  logic [1:0]        compNegSel,
    output var  logic              compPosConn,
    input  wire logic              sleepMode,
    input  wire logic              timer2Pwm,
    input  wire logic [2:0]        ledPwm,
    input  wire logic              compResult,
    output var  logic              wakeReq,
    output var  logic              devResetReq,
    output var  logic              irq
);
    if (ADDR_W < 6) begin : g_chk
        $error("ADDR_W too small for register map");
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic [7:0]  dirQ, dataQ, pullUpQ, pullDnQ, dieQ;
    logic [pfl_pkg::ALT_W-1:0] altQ;
    logic [pfl_pkg::IRQ_W-1:0] statQ, statD, ienQ, clrV, evV;
    logic [7:0]  pinSync, pinGated, dieEff, prevQ, outD, oeND;
    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0] wDataQ, rdD;
    logic [3:0]  wStrbQ;
    logic        awHeldQ, wHeldQ, wrFire, wrHit, rdHit;
    logic        rstPinEn, intSrc, intPrevQ, intEdge, wakeEv;
    logic [2:0]  armQ;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] laneWr(input logic [7:0] old,
                                          input logic [7:0] dat,
                                          input logic       strb);
        laneWr = strb ? dat : old;
    endfunction

    function automatic logic isMapped(input logic [5:0] a);
        case ({a[5:2], 2'b00})
            pfl_pkg::OFF_DIR, pfl_pkg::OFF_DATA, pfl_pkg::OFF_PULLUP,
            pfl_pkg::OFF_PULLDN, pfl_pkg::OFF_DIE, pfl_pkg::OFF_PIN,
            pfl_pkg::OFF_ALT, pfl_pkg::OFF_ISTAT, pfl_pkg::OFF_ICLR,
            pfl_pkg::OFF_IEN: isMapped = 1'b1;
            default:          isMapped = 1'b0;
        endcase
    endfunction

    function automatic logic [5:0] wordOf(input logic [ADDR_W-1:0] a);
        wordOf = {a[5:2], 2'b00};
    endfunction

    pfl_sync #(.W(8)) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .d       (pinIn),
        .q       (pinSync)
    );

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    assign wrFire = awHeldQ && wHeldQ && !bvalid;
    assign wrHit  = isMapped(wordOf(awAddrQ));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
            awAddrQ <= '0;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= pfl_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeldQ <= 1'b1;
                awready <= 1'b0;
                awAddrQ <= awaddr;
            end
            if (wvalid && wready) begin
                wHeldQ <= 1'b1;
                wready <= 1'b0;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp  <= wrHit ? pfl_pkg::RESP_OKAY : pfl_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awHeldQ <= 1'b0;
                wHeldQ  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            dirQ    <= pfl_pkg::BYTE_ZERO;
            dataQ   <= pfl_pkg::BYTE_ZERO;
            pullUpQ <= pfl_pkg::BYTE_ZERO;
            pullDnQ <= pfl_pkg::BYTE_ZERO;
            dieQ    <= pfl_pkg::DIE_RST;
            altQ    <= pfl_pkg::ALT_RST;
            ienQ    <= pfl_pkg::IRQ_RST;
        end else if (wrFire) begin
            case (wordOf(awAddrQ))
                pfl_pkg::OFF_DIR:    dirQ <= laneWr(dirQ, wDataQ[7:0],
                                         wStrbQ[0]) & pfl_pkg::PIN_MASK;
                pfl_pkg::OFF_DATA:   dataQ <= laneWr(dataQ, wDataQ[7:0],
                                         wStrbQ[0]) & pfl_pkg::PIN_MASK;
                pfl_pkg::OFF_PULLUP: pullUpQ <= laneWr(pullUpQ, wDataQ[7:0],
                                         wStrbQ[0]) & pfl_pkg::PIN_MASK;
                pfl_pkg::OFF_PULLDN: pullDnQ <= laneWr(pullDnQ, wDataQ[7:0],
                                         wStrbQ[0]) & pfl_pkg::PIN_MASK;
                pfl_pkg::OFF_DIE:    dieQ <= laneWr(dieQ, wDataQ[7:0],
                                         wStrbQ[0]) & pfl_pkg::PIN_MASK;
                pfl_pkg::OFF_ALT: begin
                    altQ[7:0]  <= laneWr(altQ[7:0], wDataQ[7:0], wStrbQ[0]);
                    altQ[11:8] <= wStrbQ[1] ? wDataQ[11:8] : altQ[11:8];
                end
                pfl_pkg::OFF_IEN: if (wStrbQ[0]) begin
                    ienQ <= wDataQ[pfl_pkg::IRQ_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // input gating, edge and wake detect
    // ------------------------------------------------------------
    always_comb begin
        rstPinEn = altQ[pfl_pkg::ALT_XRST];
        dieEff   = dieQ & pfl_pkg::PIN_MASK;
        if (altQ[pfl_pkg::ALT_P7ANA]) begin
            dieEff = dieEff & ~pfl_pkg::P7_BIT;
        end
        pinGated = pinSync & dieEff;
        intSrc   = altQ[pfl_pkg::ALT_ISEL] ? pinGated[0]
                                           : (pinGated[5] && !rstPinEn);
        intEdge  = armQ[2] && (intSrc != intPrevQ);
        wakeEv   = armQ[2] && sleepMode && dieQ[5] && !rstPinEn
                   && (pinGated[5] != prevQ[5]);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prevQ    <= pfl_pkg::BYTE_ZERO;
            intPrevQ <= 1'b0;
            armQ     <= '0;
        end else begin
            prevQ    <= pinGated;
            intPrevQ <= intSrc;
            // no edges until synchroniser holds real levels
            armQ     <= {armQ[1:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // interrupt status, set beats clear
    // ------------------------------------------------------------
    always_comb begin
        clrV = '0;
        if (wrFire && wordOf(awAddrQ) == pfl_pkg::OFF_ICLR && wStrbQ[0]) begin
            clrV = wDataQ[pfl_pkg::IRQ_W-1:0];
        end
        evV = '0;
        evV[pfl_pkg::ST_EXTIRQ] = intEdge;
        evV[pfl_pkg::ST_WAKE]   = wakeEv;
        statD = (statQ & ~clrV) | evV;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            statQ <= pfl_pkg::IRQ_RST;
            irq   <= 1'b0;
        end else begin
            statQ <= statD;
            irq   <= |(statD & ienQ);
        end
    end

    // ------------------------------------------------------------
    // pin output mux
    // ------------------------------------------------------------
    always_comb begin
        outD = dataQ & pfl_pkg::PIN_MASK;
        oeND = ~(dirQ & pfl_pkg::PIN_MASK);
        if (altQ[pfl_pkg::ALT_T2EN]) begin
            if (altQ[pfl_pkg::ALT_T2SEL]) begin
                outD[4] = timer2Pwm;
                oeND[4] = 1'b0;
            end else begin
                outD[3] = timer2Pwm;
                oeND[3] = 1'b0;
            end
        end
        if (altQ[pfl_pkg::ALT_LP0EN]) begin
            outD[3] = ledPwm[0];
            oeND[3] = 1'b0;
        end
        if (altQ[pfl_pkg::ALT_LP1EN]) begin
            outD[4] = ledPwm[1];
            oeND[4] = 1'b0;
        end
        if (altQ[pfl_pkg::ALT_LP2EN]) begin
            if (altQ[pfl_pkg::ALT_LP2SEL]) begin
                outD[7] = ledPwm[2];
                oeND[7] = 1'b0;
            end else begin
                outD[0] = ledPwm[2];
                oeND[0] = 1'b0;
            end
        end
        if (altQ[pfl_pkg::ALT_CMPOEN]) begin
            outD[0] = compResult;
            oeND[0] = 1'b0;
        end
        if (rstPinEn) begin
            outD[5] = 1'b0;
            oeND[5] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinOut      <= pfl_pkg::BYTE_ZERO;
            pinOeN      <= ~pfl_pkg::BYTE_ZERO;
            pullUpEn    <= pfl_pkg::BYTE_ZERO;
            pullDownEn  <= pfl_pkg::BYTE_ZERO;
            digInEn     <= pfl_pkg::BYTE_ZERO;
            compNegSel  <= pfl_pkg::NEG_P6;
            compPosConn <= 1'b0;
            wakeReq     <= 1'b0;
            devResetReq <= 1'b0;
        end else begin
            pinOut      <= outD;
            pinOeN      <= oeND;
            pullUpEn    <= pullUpQ & pfl_pkg::PIN_MASK;
            pullDownEn  <= pullDnQ & pfl_pkg::PIN_MASK;
            digInEn     <= dieEff;
            compNegSel  <= altQ[pfl_pkg::ALT_NEGHI:pfl_pkg::ALT_NEGLO];
            compPosConn <= 1'b1;
            wakeReq     <= wakeEv;
            devResetReq <= rstPinEn && !pinSync[5];
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    assign rdHit = isMapped(wordOf(araddr));

    always_comb begin
        rdD = 32'h0000_0000;
        case (wordOf(araddr))
            pfl_pkg::OFF_DIR:    rdD[7:0] = dirQ;
            pfl_pkg::OFF_DATA:   rdD[7:0] = dataQ;
            pfl_pkg::OFF_PULLUP: rdD[7:0] = pullUpQ;
            pfl_pkg::OFF_PULLDN: rdD[7:0] = pullDnQ;
            pfl_pkg::OFF_DIE:    rdD[7:0] = dieQ;
            pfl_pkg::OFF_PIN:    rdD[7:0] = pinGated;
            pfl_pkg::OFF_ALT:    rdD[pfl_pkg::ALT_W-1:0] = altQ;
            pfl_pkg::OFF_ISTAT:  rdD[pfl_pkg::IRQ_W-1:0] = statQ;
            pfl_pkg::OFF_IEN:    rdD[pfl_pkg::IRQ_W-1:0] = ienQ;
            default:             rdD = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= pfl_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rdD;
            rresp   <= rdHit ? pfl_pkg::RESP_OKAY : pfl_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_DIR_DRIVES: assert property (
        dirQ[6] |=> !pinOeN[6] && pinOut[6] == $past(dataQ[6]))
        else $error("pin6 output not driven from latch");
    AST_DIE_GATE: assert property (
        !dieQ[6] |-> !pinGated[6] ##1 !digInEn[6])
        else $error("pin6 digital input not gated");
    AST_NO_WAKE: assert property (
        !dieQ[5] |=> !wakeReq)
        else $error("wake with pin5 input disabled");
    AST_EDGE_IRQ: assert property (
        intEdge |=> statQ[pfl_pkg::ST_EXTIRQ])
        else $error("edge did not set irq status");
    AST_P7_ANALOG: assert property (
        altQ[pfl_pkg::ALT_P7ANA] |=> !digInEn[7])
        else $error("pin7 digital input on in analog mode");
    AST_T2_PIN3: assert property (
        altQ[pfl_pkg::ALT_T2EN] && !altQ[pfl_pkg::ALT_T2SEL]
        && !altQ[pfl_pkg::ALT_LP0EN]
        |=> pinOut[3] == $past(timer2Pwm) && !pinOeN[3])
        else $error("timer2 pwm not on pin3");
    AST_CMP_OUT: assert property (
        altQ[pfl_pkg::ALT_CMPOEN] |=> pinOut[0] == $past(compResult))
        else $error("comparator result not on pin0");
    AST_XRST: assert property (
        rstPinEn && !pinSync[5] |=> devResetReq && pinOeN[5])
        else $error("external reset not raised");
    AST_OVERRIDE: assert property (
        altQ[pfl_pkg::ALT_LP1EN] && !dataQ[4] && ledPwm[1]
        |=> pinOut[4])
        else $error("alternate function lost to latch");
    AST_DEAD_PINS: assert property (
        pinOeN[1] && pinOeN[2] && !pullUpEn[1] && !pullDownEn[2]
        && !pullUpEn[2] && !pullDownEn[1]
        && !digInEn[1] && !digInEn[2])
        else $error("unbonded pin bits active");

    COV_IRQ:  cover property (intEdge ##1 irq);
    COV_WAKE: cover property (wakeEv ##1 wakeReq);
    COV_RST:  cover property (devResetReq);
    COV_WR:   cover property (bvalid && bready);
endmodule // pfl_port_a
`default_nettype wire

// ### bench/pfl_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfl_pin_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOeN,
    input  wire logic [7:0] pullUpEn,
    input  wire logic [7:0] pullDownEn,
    input  wire logic [7:0] extEn,
    input  wire logic [7:0] extLvl,
    output var  logic [7:0] pinIn
);
    // ------------------------------------------------------------
    // board side of each pin
    // ------------------------------------------------------------
    logic [7:0] floatQ = 8'h5a;

    // undriven lines wander every cycle
    always @(posedge ref_clk) begin
        floatQ <= ~floatQ;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pinOeN[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extLvl[i];
            end else if (pullUpEn[i]) begin
                pinIn[i] = 1'b1;
            end else if (pullDownEn[i]) begin
                pinIn[i] = 1'b0;
            end else begin
                pinIn[i] = floatQ[i];
            end
        end
    end
endmodule // pfl_pin_model
`default_nettype wire

// ### bench/port_a_pin_function_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
module port_a_pin_function_logic_test;
    logic ref_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, sleepMode = 0, timer2Pwm = 0;
    logic compResult = 0, awready, wready, bvalid, arready, rvalid;
    logic wakeReq, devResetReq, irq, compPosConn;
    logic [5:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic [2:0] ledPwm = 0;
    logic [1:0] bresp, rresp, compNegSel, rs;
    logic [7:0] pinIn, pinOut, pinOeN, pullUpEn, pullDownEn, digInEn;
    logic [7:0] extEn = 0, extLvl = 0;
    int err_count = 0, n_checks = 0, wakeCnt = 0;
    logic [11:0] altTab [7] = '{12'h001, 12'h003, 12'h004, 12'h008,
                                12'h010, 12'h030, 12'h040};
    logic [7:0] pinTab [7] = '{8'h08, 8'h10, 8'h08, 8'h10,
                               8'h01, 8'h80, 8'h01};

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (wakeReq === 1'b1) wakeCnt++;

    pfl_port_a u_pfl_port_a (.ref_clk(ref_clk), .nrst(nrst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
        .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .digInEn(digInEn),
        .compNegSel(compNegSel), .compPosConn(compPosConn),
        .sleepMode(sleepMode), .timer2Pwm(timer2Pwm), .ledPwm(ledPwm),
        .compResult(compResult), .wakeReq(wakeReq),
        .devResetReq(devResetReq), .irq(irq));

    pfl_pin_model u_pfl_pin_model (.ref_clk(ref_clk), .pinOut(pinOut),
        .pinOeN(pinOeN), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
        .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn));

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (exp !== got) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(logic [5:0] a, logic [31:0] d, output logic [1:0] r);
        bit ad = 0, wd = 0;
        int n = 0;
        @(posedge ref_clk);
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= 4'hf;
        wvalid <= 1; bready <= 1;
        forever begin
            @(posedge ref_clk);
            n++;
            if (!ad && awready) begin ad = 1; awvalid <= 0; end
            if (!wd && wready) begin wd = 1; wvalid <= 0; end
            if (bvalid || n > 100) begin r = bresp; bready <= 0; break; end
        end
        if (n > 100) chk("write wait", 0, 1);
    endtask

    task automatic rdr(logic [5:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        bit ad = 0;
        int n = 0;
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge ref_clk);
            n++;
            if (!ad && arready) begin ad = 1; arvalid <= 0; end
            if (rvalid || n > 100) begin
                d = rdata; r = rresp; rready <= 0; break;
            end
        end
        if (n > 100) chk("read wait", 0, 1);
    endtask

    task automatic w(logic [5:0] a, logic [31:0] d);
        wr(a, d, rs);
        chk("bresp", pfl_pkg::RESP_OKAY, rs);
    endtask

    task automatic rc(string nm, logic [5:0] a, logic [31:0] e);
        rdr(a, rd, rs);
        chk(nm, e, rd);
    endtask

    task automatic ext(logic [7:0] en, logic [7:0] lv);
        @(posedge ref_clk);
        extEn <= en; extLvl <= lv;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        results;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1;
        rc("die reset", pfl_pkg::OFF_DIE, 32'h0000_00f9);
        rc("alt reset", pfl_pkg::OFF_ALT, 32'h0);
        chk("oe reset", 32'hff, {24'h0, pinOeN});
        w(pfl_pkg::OFF_DIR, 32'hff);
        w(pfl_pkg::OFF_DATA, 32'ha5);
        w(pfl_pkg::OFF_PULLUP, 32'hf0);
        w(pfl_pkg::OFF_PULLDN, 32'h0f);
        repeat (3) @(posedge ref_clk);
        rc("dir bits", pfl_pkg::OFF_DIR, 32'hf9);
        rc("pulldn bits", pfl_pkg::OFF_PULLDN, 32'h09);
        chk("oe", 32'h06, {24'h0, pinOeN});
        chk("out", 32'ha1, {24'h0, pinOut});
        chk("pulls", 32'hf009, {16'h0, pullUpEn, pullDownEn});
        $display("test pin setup done");
        w(pfl_pkg::OFF_DIR, 32'h0);
        repeat (6) @(posedge ref_clk);
        rc("pull read", pfl_pkg::OFF_PIN, 32'hf0);
        w(pfl_pkg::OFF_DIE, 32'h29);
        ext(8'hf9, 8'hff);
        rc("gated read", pfl_pkg::OFF_PIN, 32'h29);
        chk("dig en", 32'h29, {24'h0, digInEn});
        w(pfl_pkg::OFF_DIE, 32'hf9);
        w(pfl_pkg::OFF_ALT, 32'h800);
        repeat (6) @(posedge ref_clk);
        rc("analog p7", pfl_pkg::OFF_PIN, 32'h79);
        chk("dig en p7", 32'h79, {24'h0, digInEn});
        $display("test input gating done");
        ext(8'h00, 8'h00);
        w(pfl_pkg::OFF_DIR, 32'hff);
        for (int i = 0; i < 7; i++) begin
            w(pfl_pkg::OFF_DATA, 32'h0);
            w(pfl_pkg::OFF_ALT, {20'h0, altTab[i]});
            timer2Pwm <= 1; ledPwm <= 3'h7; compResult <= 1;
            repeat (3) @(posedge ref_clk);
            chk("alt hi", {24'h0, pinTab[i]}, {24'h0, pinOut});
            w(pfl_pkg::OFF_DATA, 32'hff);
            timer2Pwm <= 0; ledPwm <= 3'h0; compResult <= 0;
            repeat (3) @(posedge ref_clk);
            chk("alt lo", {24'h0, 8'hf9 & ~pinTab[i]},
                {24'h0, pinOut});
        end
        for (int s = 0; s < 3; s++) begin
            w(pfl_pkg::OFF_ALT, 32'(s) << pfl_pkg::ALT_NEGLO);
            repeat (2) @(posedge ref_clk);
            chk("neg sel", 32'(s), {30'h0, compNegSel});
            chk("pos conn", 32'h1, {31'h0, compPosConn});
        end
        $display("test alternate outputs done");
        w(pfl_pkg::OFF_DIR, 32'h0);
        w(pfl_pkg::OFF_ALT, 32'h0);
        ext(8'h21, 8'h00);
        w(pfl_pkg::OFF_ICLR, 32'h3);
        w(pfl_pkg::OFF_IEN, 32'h1);
        ext(8'h21, 8'h20);
        chk("irq rise", 32'h1, {31'h0, irq});
        rc("status", pfl_pkg::OFF_ISTAT, 32'h1);
        w(pfl_pkg::OFF_ICLR, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq clr", 32'h0, {31'h0, irq});
        ext(8'h21, 8'h00);
        chk("irq fall", 32'h1, {31'h0, irq});
        w(pfl_pkg::OFF_IEN, 32'h0);
        w(pfl_pkg::OFF_ALT, 32'h200);
        repeat (6) @(posedge ref_clk);
        w(pfl_pkg::OFF_ICLR, 32'h3);
        ext(8'h21, 8'h01);
        chk("irq masked", 32'h0, {31'h0, irq});
        rc("status p0", pfl_pkg::OFF_ISTAT, 32'h1);
        $display("test interrupt done");
        w(pfl_pkg::OFF_ALT, 32'h0);
        w(pfl_pkg::OFF_DIE, 32'hd9);
        sleepMode <= 1;
        repeat (6) @(posedge ref_clk);
        wakeCnt = 0;
        ext(8'h21, 8'h21);
        chk("no wake", 32'h0, 32'(wakeCnt));
        w(pfl_pkg::OFF_DIE, 32'hf9);
        repeat (6) @(posedge ref_clk);
        wakeCnt = 0;
        ext(8'h21, 8'h01);
        chk("wake", 32'h1, 32'(wakeCnt));
        sleepMode <= 0;
        $display("test wake done");
        w(pfl_pkg::OFF_ALT, 32'h400);
        ext(8'h21, 8'h01);
        chk("ext rst lo", 32'h1, {31'h0, devResetReq});
        ext(8'h21, 8'h21);
        chk("ext rst hi", 32'h0, {31'h0, devResetReq});
        rdr(6'h28, rd, rs);
        chk("unmapped rresp", pfl_pkg::RESP_SLVERR, rs);
        chk("unmapped rdata", 32'h0, rd);
        wr(6'h3c, 32'hff, rs);
        chk("unmapped bresp", pfl_pkg::RESP_SLVERR, rs);
        $display("test reset pin and map done");
        nrst <= 0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1;
        repeat (6) @(posedge ref_clk);
        rc("die rereset", pfl_pkg::OFF_DIE, 32'h0000_00f9);
        rc("stat rereset", pfl_pkg::OFF_ISTAT, 32'h0);
        chk("oe rereset", 32'hff, {24'h0, pinOeN});
        $display("test mid reset done");
        results;
    end
endmodule // port_a_pin_function_logic_test
`default_nettype wire
